// ==== rtl/ocsc_pkg.sv ====
// Constants and types for the channel six output control block
package ocsc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] OCSC_IDX_CTL   = 8'h29;
  localparam logic [7:0] OCSC_IDX_DIV   = 8'h2A;
  localparam logic [7:0] OCSC_IDX_STAT  = 8'h2B;

  // Values after reset
  localparam logic [7:0] OCSC_RST_CTL   = 8'h18;
  localparam logic [7:0] OCSC_RST_DIV   = 8'h05;

  // Field positions in the control register
  localparam int         OCSC_SRC_LSB   = 6;
  localparam int         OCSC_FMT_LSB   = 4;
  localparam int         OCSC_M1_LSB    = 2;
  localparam int         OCSC_M2_LSB    = 0;

  // Status register bit positions
  localparam int         OCSC_ST_RUN    = 7;
  localparam int         OCSC_ST_DIVON  = 6;
  localparam int         OCSC_ST_DRVON  = 5;
  localparam int         OCSC_ST_CLK    = 4;

  // AXI responses
  localparam logic [1:0] OCSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCSC_RESP_SLV  = 2'h2;

  typedef enum logic [1:0] {
    OCSC_SRC_SYNTH1 = 2'h0,
    OCSC_SRC_SYNTH2 = 2'h1,
    OCSC_SRC_PRIREF = 2'h2,
    OCSC_SRC_SECREF = 2'h3
  } ocsc_src_t;

  typedef enum logic [1:0] {
    OCSC_FMT_OFF  = 2'h0,
    OCSC_FMT_DIFF = 2'h1,
    OCSC_FMT_HCSL = 2'h2,
    OCSC_FMT_CMOS = 2'h3
  } ocsc_fmt_t;

  typedef enum logic [1:0] {
    OCSC_ST_BOOT = 2'h0,
    OCSC_ST_OPER = 2'h1
  } ocsc_state_t;

endpackage

// ==== rtl/ocsc_divider.sv ====
// Channel divider: divides edges of a sampled source by code plus one
`timescale 1ns/100ps
module ocsc_divider
  import ocsc_pkg::*;
#(
  parameter int CODE_W = 8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              src_i,
  input  wire logic              clr_i,
  input  wire logic              bypass_i,
  input  wire logic [CODE_W-1:0] code_i,
  output      logic              clk_o
);

  logic              src_q;
  logic [CODE_W-1:0] cnt_q;
  logic [CODE_W-1:0] cnt_d;
  logic [CODE_W:0]   half;
  logic              rise;

  // Period is code plus one source periods; high for the first half
  assign rise  = src_i & ~src_q;
  assign cnt_d = (cnt_q == code_i) ? '0 : CODE_W'(cnt_q + 1'b1);
  assign half  = ({1'b0, code_i} + 1'b1) >> 1;

  // Previous source level for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_q <= 1'b0;
    else
      src_q <= src_i;
  end

  // Edge counter; restarts on a source or ratio change to avoid runt cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr_i || bypass_i)
      cnt_q <= '0;
    else if (rise)
      cnt_q <= cnt_d;
  end

  // Bypass and ratio one follow the source level directly
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clk_o <= 1'b0;
    else if (bypass_i || code_i == '0)
      clk_o <= src_i;
    else if (rise)
      clk_o <= ({1'b0, cnt_d} < half);
  end

endmodule

// ==== rtl/ocsc_driver.sv ====
// Output driver control: format, tail current, load and pin drive
`timescale 1ns/100ps
module ocsc_driver
  import ocsc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clk_i,
  input  wire logic [1:0] fmt_i,
  input  wire logic [1:0] mode1_i,
  input  wire logic [1:0] mode2_i,
  output      logic       out_p,
  output      logic       out_p_oe,
  output      logic       out_n,
  output      logic       out_n_oe,
  output      logic [4:0] tail_ma,
  output      logic [7:0] load_ohm,
  output      logic       drv_on
);

  ocsc_fmt_t fmt;
  assign fmt = ocsc_fmt_t'(fmt_i);

  // One LVCMOS pin: 0 tri-state, 1 low, 2 inverted, 3 true
  function automatic logic [1:0] cmos_pin(input logic [1:0] m, input logic c);
    case (m)
      2'h0:    cmos_pin = 2'b00;
      2'h1:    cmos_pin = 2'b10;
      2'h2:    cmos_pin = {1'b1, ~c};
      default: cmos_pin = {1'b1, c};
    endcase
  endfunction

  // Registered decode of format and modes into driver controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {out_p_oe, out_p, out_n_oe, out_n} <= 4'h0;
      tail_ma  <= 5'h00;
      load_ohm <= 8'h00;
      drv_on   <= 1'b0;
    end
    else
    begin
      unique case (fmt)
        OCSC_FMT_OFF:
        begin
          {out_p_oe, out_p, out_n_oe, out_n} <= 4'h0;
          tail_ma  <= 5'h00;
          load_ohm <= 8'h00;
          drv_on   <= 1'b0;
        end
        OCSC_FMT_CMOS:
        begin
          {out_p_oe, out_p} <= cmos_pin(mode1_i, clk_i);
          {out_n_oe, out_n} <= cmos_pin(mode2_i, clk_i);
          tail_ma  <= 5'h00;
          load_ohm <= 8'h00;
          drv_on   <= mode1_i[1] | mode2_i[1];
        end
        default:
        begin
          // Differential pair; HCSL load code 0 floats the pair
          out_p    <= clk_i;
          out_n    <= ~clk_i;
          out_p_oe <= !(fmt == OCSC_FMT_HCSL && mode2_i == 2'h0);
          out_n_oe <= !(fmt == OCSC_FMT_HCSL && mode2_i == 2'h0);
          drv_on   <= 1'b1;
          case (mode1_i)
            2'h0:    tail_ma <= 5'h04;
            2'h1:    tail_ma <= 5'h06;
            2'h2:    tail_ma <= 5'h08;
            default: tail_ma <= (fmt == OCSC_FMT_HCSL) ? 5'h10 : 5'h08;
          endcase
          if (fmt == OCSC_FMT_HCSL)
            case (mode2_i)
              2'h0:    load_ohm <= 8'h00;
              2'h1:    load_ohm <= 8'h32;
              2'h2:    load_ohm <= 8'h64;
              default: load_ohm <= 8'hC8;
            endcase
          else
            load_ohm <= 8'h00;
        end
      endcase
    end
  end

endmodule

// ==== rtl/ocsc_top.sv ====
// Channel six output control: AXI4-Lite registers, source mux, divider, driver
`timescale 1ns/100ps
module ocsc_top
  import ocsc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // AXI4-Lite read data
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Clock sources, sampled on aclk
  input  wire logic              first_synth_loop,
  input  wire logic              second_synth_loop,
  input  wire logic              pri_ref_clk,
  input  wire logic              sec_ref_clk,
  // Nonvolatile startup image
  input  wire logic              nvm_valid,
  input  wire logic [7:0]        nvm_ctl,
  input  wire logic [7:0]        nvm_div,
  // Output pins and driver controls
  output      logic              out_p,
  output      logic              out_p_oe,
  output      logic              out_n,
  output      logic              out_n_oe,
  output      logic [4:0]        tail_ma,
  output      logic [7:0]        load_ohm,
  output      logic              drv_on
);

  // Byte addresses from register indices
  localparam logic [ADDR_W-1:0] ADDR_CTL  = ADDR_W'({OCSC_IDX_CTL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_DIV  = ADDR_W'({OCSC_IDX_DIV, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_STAT = ADDR_W'({OCSC_IDX_STAT, 2'b00});

  ocsc_state_t       state_q;
  logic [7:0]        ctl_q;
  logic [7:0]        div_q;

  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte_q;
  logic              wbyte_en_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  logic              oper;
  logic              do_write;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;

  ocsc_src_t         src_sel;
  ocsc_src_t         src_prev_q;
  logic [7:0]        div_prev_q;
  logic              src_level;
  logic              use_synth;
  logic              div_clr;
  logic              chan_clk;
  logic [7:0]        status;

  assign oper = (state_q == OCSC_ST_OPER);

  // Startup sequence: one boot cycle to pick up the stored image
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= OCSC_ST_BOOT;
    else
    begin
      unique case (state_q)
        OCSC_ST_BOOT: state_q <= OCSC_ST_OPER;
        OCSC_ST_OPER: state_q <= OCSC_ST_OPER;
        default:      state_q <= OCSC_ST_BOOT;
      endcase
    end
  end

  // Bus handshakes; the slave holds off while booting or answering
  assign s_axi_awready = oper & ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = oper & ~w_held_q & ~bvalid_q;
  assign s_axi_arready = oper & ~rvalid_q;

  assign aw_hs    = s_axi_awvalid & s_axi_awready;
  assign w_hs     = s_axi_wvalid & s_axi_wready;
  assign ar_hs    = s_axi_arvalid & s_axi_arready;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;

  // Write address capture; address and data may come in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (aw_hs)
    begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_q <= 1'b0;
  end

  // Write data capture; only the low byte lane carries register bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q   <= 1'b0;
      wbyte_q    <= 8'h00;
      wbyte_en_q <= 1'b0;
    end
    else if (w_hs)
    begin
      w_held_q   <= 1'b1;
      wbyte_q    <= s_axi_wdata[7:0];
      wbyte_en_q <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_held_q <= 1'b0;
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= OCSC_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      if (awaddr_q == ADDR_CTL || awaddr_q == ADDR_DIV || awaddr_q == ADDR_STAT)
        bresp_q <= OCSC_RESP_OKAY;
      else
        bresp_q <= OCSC_RESP_SLV;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Control register: boot image first, then software writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl_q <= OCSC_RST_CTL;
    else if (state_q == OCSC_ST_BOOT && nvm_valid)
      ctl_q <= nvm_ctl;
    else if (do_write && wbyte_en_q && awaddr_q == ADDR_CTL)
      ctl_q <= wbyte_q;
  end

  // Divider register, same load order as control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= OCSC_RST_DIV;
    else if (state_q == OCSC_ST_BOOT && nvm_valid)
      div_q <= nvm_div;
    else if (do_write && wbyte_en_q && awaddr_q == ADDR_DIV)
      div_q <= wbyte_q;
  end

  // Status is read-only; writes to it are accepted and dropped
  assign status = {oper, use_synth, drv_on, chan_clk, 4'h0};

  // Read path; data is registered at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= OCSC_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= OCSC_RESP_OKAY;
      if (s_axi_araddr == ADDR_CTL)
        rdata_q <= {24'h00_0000, ctl_q};
      else if (s_axi_araddr == ADDR_DIV)
        rdata_q <= {24'h00_0000, div_q};
      else if (s_axi_araddr == ADDR_STAT)
        rdata_q <= {24'h00_0000, status};
      else
      begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= OCSC_RESP_SLV;
      end
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Source mux
  assign src_sel = ocsc_src_t'(ctl_q[OCSC_SRC_LSB +: 2]);

  always_comb
  begin
    unique case (src_sel)
      OCSC_SRC_SYNTH1: src_level = first_synth_loop;
      OCSC_SRC_SYNTH2: src_level = second_synth_loop;
      OCSC_SRC_PRIREF: src_level = pri_ref_clk;
      OCSC_SRC_SECREF: src_level = sec_ref_clk;
    endcase
  end

  // Divider only on synth paths; references skip it
  assign use_synth = (src_sel == OCSC_SRC_SYNTH1) || (src_sel == OCSC_SRC_SYNTH2);

  // Track setting changes so the divider restarts cleanly
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_prev_q <= OCSC_SRC_SYNTH1;
      div_prev_q <= OCSC_RST_DIV;
    end
    else
    begin
      src_prev_q <= src_sel;
      div_prev_q <= div_q;
    end
  end

  assign div_clr = (src_prev_q != src_sel) || (div_prev_q != div_q);

  // Channel divider; sample-based, so usable source rates go up to aclk / 2
  ocsc_divider #(
    .CODE_W   (8)
  ) u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .src_i    (src_level),
    .clr_i    (div_clr),
    .bypass_i (~use_synth),
    .code_i   (div_q),
    .clk_o    (chan_clk)
  );

  // Output driver decode
  ocsc_driver u_drv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clk_i    (chan_clk),
    .fmt_i    (ctl_q[OCSC_FMT_LSB +: 2]),
    .mode1_i  (ctl_q[OCSC_M1_LSB +: 2]),
    .mode2_i  (ctl_q[OCSC_M2_LSB +: 2]),
    .out_p    (out_p),
    .out_p_oe (out_p_oe),
    .out_n    (out_n),
    .out_n_oe (out_n_oe),
    .tail_ma  (tail_ma),
    .load_ohm (load_ohm),
    .drv_on   (drv_on)
  );

endmodule

// ==== verif/ocsc_checker.sv ====
// Port-level assertions for the channel six output control block
`timescale 1ns/100ps
module ocsc_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        out_p,
  input wire logic        out_p_oe,
  input wire logic        out_n,
  input wire logic        out_n_oe,
  input wire logic [4:0]  tail_ma,
  input wire logic [7:0]  load_ohm
);
  // One clock domain, so clock and disable are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Write takes both channels, answer comes two cycles later
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  chk_wr_answer: assert property (wr_taken |=> wr_answer)
    else $error("write response not on the expected cycle");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not on the expected cycle");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("new write accepted while response pending");
  chk_rd_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data above the low byte not zero");
  chk_tail_set: assert property (tail_ma inside {5'h00, 5'h04, 5'h06, 5'h08, 5'h10})
    else $error("tail current not a legal value");
  chk_load_set: assert property (load_ohm inside {8'h00, 8'h32, 8'h64, 8'hc8})
    else $error("load not a legal value");
  chk_load_hcsl: assert property (load_ohm != 8'h00 |-> tail_ma != 5'h00 && out_p_oe && out_n_oe)
    else $error("load set without a driven differential pair");
  chk_diff_pair: assert property (tail_ma != 5'h00 && out_p_oe |-> out_n_oe && out_n == !out_p)
    else $error("differential pins not complementary");
  chk_boot_idle: assert property ($rose(aresetn) |-> !s_axi_awready && !s_axi_arready)
    else $error("bus ready during startup load");
endmodule

bind ocsc_top ocsc_checker u_chk
(
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .out_p         (out_p),
  .out_p_oe      (out_p_oe),
  .out_n         (out_n),
  .out_n_oe      (out_n_oe),
  .tail_ma       (tail_ma),
  .load_ohm      (load_ohm)
);

// ==== verif/ocsc_bench.sv ====
// Self-checking bench for the channel six output control block
`timescale 1ns/100ps
module ocsc_bench
  import ocsc_pkg::*;
;
  localparam logic [11:0] CTL_A = {2'h0, OCSC_IDX_CTL, 2'h0};
  localparam logic [11:0] DIV_A = {2'h0, OCSC_IDX_DIV, 2'h0};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        first_synth_loop, second_synth_loop, pri_ref_clk, sec_ref_clk, nvm_valid;
  logic        out_p, out_p_oe, out_n, out_n_oe, drv_on;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  nvm_ctl, nvm_div, rc, rd;
  logic [4:0]  tail_ma;
  logic [7:0]  load_ohm;
  logic [1:0]  wq[$];
  logic [33:0] rq[$];
  int          failures, n_tests, tick, n, seed;
  logic [1:0]  tsrc[6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
  logic [7:0]  tdiv[6] = '{8'h00, 8'h02, 8'hff, 8'h01, 8'h05, 8'h05};
  int          tper[6] = '{2, 6, 512, 8, 6, 8};

  ocsc_top dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .first_synth_loop(first_synth_loop), .second_synth_loop(second_synth_loop),
    .pri_ref_clk(pri_ref_clk), .sec_ref_clk(sec_ref_clk), .nvm_valid(nvm_valid), .nvm_ctl(nvm_ctl),
    .nvm_div(nvm_div), .out_p(out_p), .out_p_oe(out_p_oe), .out_n(out_n), .out_n_oe(out_n_oe),
    .tail_ma(tail_ma), .load_ohm(load_ohm), .drv_on(drv_on)
  );

  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Sources with periods of 2, 4, 6 and 8 cycles, so each selection is told apart
  always @(posedge aclk)
  begin
    tick <= tick + 1;
    first_synth_loop <= ~first_synth_loop;
    if (tick % 2 == 0) second_synth_loop <= ~second_synth_loop;
    if (tick % 3 == 0) pri_ref_clk <= ~pri_ref_clk;
    if (tick % 4 == 0) sec_ref_clk <= ~sec_ref_clk;
  end

  task automatic note(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_wr(input logic [1:0] g, input logic [1:0] e); note(g === e, "write response"); endtask
  task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e); note(g === e, "read data"); endtask
  task automatic cmp_drv(input logic [17:0] g, input logic [17:0] e); note(g === e, "driver outputs"); endtask
  task automatic cmp_per(input int g, input int e); note(g == e, "output period"); endtask

  // Scoreboard: checked before the edge that completes the handshake
  always @(negedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready && wq.size() > 0) cmp_wr(s_axi_bresp, wq.pop_front());
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) cmp_rd({s_axi_rdata, s_axi_rresp}, rq.pop_front());
  end

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic ta, tw, tb, tv;
    wq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Response ready sometimes late, so a held response gets exercised
    s_axi_bready <= 1'($random(seed));
    tb = 1'b0;
    // Readies are combinational, so they are judged settled at the falling edge
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      tv = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tv && !tb) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tb, tv;
    rq.push_back({d, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($random(seed));
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid && s_axi_rready;
      tv = s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv && !tb) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Expected driver state from a control value; both differential formats power the driver
  task automatic chk_ctl(input logic [7:0] c);
    logic [1:0] f, m1, m2;
    logic [4:0] t;
    logic [7:0] l;
    logic       h, po, no, dv, lp, ln;
    f = c[5:4];
    m1 = c[3:2];
    m2 = c[1:0];
    h = (f == OCSC_FMT_HCSL);
    t = m1 == 2'h0 ? 5'h04 : m1 == 2'h1 ? 5'h06 : (m1 == 2'h3 && h) ? 5'h10 : 5'h08;
    if (f == OCSC_FMT_OFF || f == OCSC_FMT_CMOS) t = 5'h00;
    l = !h ? 8'h00 : m2 == 2'h0 ? 8'h00 : m2 == 2'h1 ? 8'h32 : m2 == 2'h2 ? 8'h64 : 8'hc8;
    po = f == OCSC_FMT_DIFF || (h && m2 != 2'h0) || (f == OCSC_FMT_CMOS && m1 != 2'h0);
    no = f == OCSC_FMT_DIFF || (h && m2 != 2'h0) || (f == OCSC_FMT_CMOS && m2 != 2'h0);
    dv = f == OCSC_FMT_DIFF || h || (f == OCSC_FMT_CMOS && (m1[1] || m2[1]));
    lp = (f == OCSC_FMT_CMOS && m1 == 2'h1) ? out_p : 1'b0;
    ln = (f == OCSC_FMT_CMOS && m2 == 2'h1) ? out_n : 1'b0;
    cmp_drv({lp, ln, drv_on, out_p_oe, out_n_oe, tail_ma, load_ohm}, {2'h0, dv, po, no, t, l});
  endtask

  // Cycles between rising edges of the positive pin, after one settling period
  task automatic per(output int k);
    logic pv;
    k = 0;
    repeat (2)
    begin
      do
      begin
        pv = out_p;
        @(negedge aclk);
      end while (!(!pv && out_p));
    end
    do
    begin
      k++;
      pv = out_p;
      @(negedge aclk);
    end while (!(!pv && out_p));
  endtask

  task automatic conclude;
    $display("Comparisons: %0d, mismatches: %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #(20000 * 10);
    failures++;
    $display("wrong value at %0t: run timed out", $time);
    conclude;
  end

  // Main sequence
  initial
  begin
    seed = 32'h0ae3;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {first_synth_loop, second_synth_loop, pri_ref_clk, sec_ref_clk, nvm_valid} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, nvm_ctl, nvm_div} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(CTL_A, {24'h00_0000, OCSC_RST_CTL}, OCSC_RESP_OKAY);
    axr(DIV_A, {24'h00_0000, OCSC_RST_DIV}, OCSC_RESP_OKAY);
    axw(12'h0b0, 32'h0000_0000, 4'hf, OCSC_RESP_SLV);
    axr(12'h0b0, 32'h0000_0000, OCSC_RESP_SLV);
    axw(DIV_A, 32'hffff_ffff, 4'hf, OCSC_RESP_OKAY);
    axw(DIV_A, 32'h0000_0000, 4'h0, OCSC_RESP_OKAY);
    axr(DIV_A, 32'h0000_00ff, OCSC_RESP_OKAY);
    for (int i = 0; i < 256; i++)
    begin
      axw(CTL_A, i, 4'hf, OCSC_RESP_OKAY);
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk_ctl(8'(i));
    end
    // True-polarity single-ended pin shows the channel clock
    for (int i = 0; i < 6; i++)
    begin
      axw(DIV_A, {24'h00_0000, tdiv[i]}, 4'hf, OCSC_RESP_OKAY);
      axw(CTL_A, {24'h00_0000, tsrc[i], 6'h3f}, 4'hf, OCSC_RESP_OKAY);
      per(n);
      cmp_per(n, tper[i]);
    end
    repeat (4)
    begin
      rd = 8'($random(seed)) & 8'h07;
      axw(DIV_A, {24'h00_0000, rd}, 4'hf, OCSC_RESP_OKAY);
      axw(CTL_A, 32'h0000_007f, 4'hf, OCSC_RESP_OKAY);
      per(n);
      cmp_per(n, 4 * (rd + 1));
    end
    // Second reset in mid-run with a stored image present
    rc = 8'($random(seed));
    rd = 8'($random(seed));
    @(posedge aclk);
    aresetn <= 1'b0;
    nvm_valid <= 1'b1;
    nvm_ctl <= rc;
    nvm_div <= rd;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(CTL_A, {24'h00_0000, rc}, OCSC_RESP_OKAY);
    axr(DIV_A, {24'h00_0000, rd}, OCSC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    conclude;
  end
endmodule
